// File: flash_host_defines.vh
// register map, field positions, opcodes and timing counts
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

`define REG_CTRL       8'h00
`define REG_ADDR       8'h04
`define REG_LEN        8'h08
`define REG_TXDATA     8'h0c
`define REG_RXDATA     8'h10
`define REG_CFG        8'h14
`define REG_STATUS     8'h18

`define CTRL_START     8
`define RXD_VALID      8
`define CFG_QUAD_OK    0
`define CFG_DUMMY10    1
`define CFG_MODE_LO    8
`define CFG_MODE_HI    15
`define CFG_WRAP_LO    16
`define CFG_WRAP_HI    18
`define ST_BUSY        0
`define ST_TX_FULL     1
`define ST_RX_VALID    2
`define ST_REFUSED     3
`define ST_CONT        4
`define ST_FLASH_BUSY  5

`define MODE_RST       8'h00
`define WRAP_RST       3'h1
`define LEN_RST        16'h0001

`define OP_QOUT_READ   8'h6b
`define OP_QIO_READ    8'heb
`define OP_PROGRAM     8'h02
`define OP_QPROGRAM    8'h32
`define OP_SECT_ERASE  8'h20
`define OP_WRAP_SET    8'h77
`define OP_WRITE_EN    8'h06
`define OP_READ_STAT   8'h05
`define OP_MODE_RESET  8'hff
`define CONT_KEY       2'b10

`define K_QOUT         4'h0
`define K_QIO          4'h1
`define K_PP           4'h2
`define K_QPP          4'h3
`define K_SE           4'h4
`define K_WRAP         4'h5
`define K_WRITE_ENABLE_CMD         4'h6
`define K_MRST         4'h7
`define K_POLL         4'h8

`define HALF_CYC       4'h4
`define GAP_TICKS      4'h4
`define QIO_WAIT_DEF   6'd4
`define QIO_WAIT_LONG  6'd8

`endif

// File: spi_tick_gen.v
// half-period enable pulse for the serial clock
`timescale 1ns/1ps
module spi_tick_gen (
  input wire clk_sys, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire run,     // count while high
  output reg tick     // one-cycle pulse every half period
);
`include "flash_host_defines.vh"
  reg [3:0] cnt_r;

  always @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else if (cnt_r == `HALF_CYC - 4'h1) begin
      cnt_r <= 4'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      tick <= 1'b0;
    end
  end
endmodule

// File: io_sync.v
// two-flop synchroniser for the four data pins
`timescale 1ns/1ps
module io_sync (
  input wire clk_sys,       // system clock
  input wire sys_rst,       // synchronous reset, active high
  input wire [3:0] pinIn,   // raw pin levels
  output reg [3:0] pinSync  // synchronised levels
);
  reg [3:0] meta_r;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= 4'h0;
      pinSync <= 4'h0;
    end else begin
      meta_r <= pinIn;
      pinSync <= meta_r;
    end
  end
endmodule

// File: flash_host_ctrl.v
// serial flash host: quad reads, program, erase, wrap setup, over APB
//
// Contract
// - 6BH, address, dummy byte, quad data out
// - EBH: address, mode, dummy all quad
// - host sets quad enable before EBH
// - quad-I/O wait 6 clocks, or 10
// - mode key 10 skips next opcode
// - other key: opcode again; reset clears
// - 77H, 24 dummy bits, 8 wrap bits
// - host sends write enable before program
// - program: opcode, address, at least one byte
// - program runs only on whole byte
// - 32H quad program needs quad enable
// - 20H plus address erases a sector
// - erase runs only after full address
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module flash_host_ctrl (
  input wire clk_sys,         // system clock, 250 MHz
  input wire sys_rst,         // synchronous reset, active high
  input wire [7:0] paddr,     // APB address
  input wire psel,            // APB select
  input wire penable,         // APB enable
  input wire pwrite,          // APB write
  input wire [31:0] pwdata,   // APB write data
  output reg [31:0] prdata,   // APB read data
  output reg pready,          // APB ready
  output reg pslverr,         // APB error, unmapped address
  output reg flashCsN,        // chip select, active low
  output reg flashSclk,       // serial clock, idles low
  input wire [3:0] ioIn,      // data pins in
  output reg [3:0] ioOut,     // data pins out
  output reg [3:0] ioOe       // data pin drive enables
);
`include "flash_host_defines.vh"
  localparam S_IDLE = 4'd0;
  localparam S_START = 4'd1;
  localparam S_LEAD = 4'd2;
  localparam S_OPC = 4'd3;
  localparam S_AX = 4'd4;
  localparam S_DUMMY = 4'd5;
  localparam S_RXD = 4'd6;
  localparam S_TXWAIT = 4'd7;
  localparam S_TXD = 4'd8;
  localparam S_FIN = 4'd9;
  localparam S_GAP = 4'd10;

  reg [3:0] state_r, segNext_r, kind_r, mainKind_r, gapCnt_r;
  reg [31:0] txShift_r;
  reg [5:0] clkLeft_r;
  reg segQuad_r;
  reg [3:0] segOe_r;
  reg [7:0] rxShift_r, rxData_r, txData_r, modeByte_r;
  reg [15:0] byteLeft_r, len_r;
  reg [23:0] addr_r;
  reg [2:0] wrapBits_r;
  reg contMode_r, flashBusy_r, refused_r, txValid_r, rxValid_r, rxSnap_r;
  reg quadOk_r, dummy10_r;
  wire [3:0] ioSync;
  wire tick;

  function [7:0] opcodeOf;
    input [3:0] k;
    begin
      case (k)
        `K_QOUT: opcodeOf = `OP_QOUT_READ;
        `K_QIO: opcodeOf = `OP_QIO_READ;
        `K_PP: opcodeOf = `OP_PROGRAM;
        `K_QPP: opcodeOf = `OP_QPROGRAM;
        `K_SE: opcodeOf = `OP_SECT_ERASE;
        `K_WRAP: opcodeOf = `OP_WRAP_SET;
        `K_WRITE_ENABLE_CMD: opcodeOf = `OP_WRITE_EN;
        `K_POLL: opcodeOf = `OP_READ_STAT;
        default: opcodeOf = `OP_MODE_RESET;
      endcase
    end
  endfunction

  function needsWren;
    input [3:0] k;
    begin
      needsWren = (k == `K_PP) || (k == `K_QPP) || (k == `K_SE);
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `REG_STATUS);
    end
  endfunction

  // address-phase segment for each command
  reg [31:0] axShift;
  reg [5:0] axClk;
  reg axQuad;
  reg [3:0] axOe;
  always @* begin
    axShift = {addr_r, 8'h00};
    axClk = 6'd24;
    axQuad = 1'b0;
    axOe = 4'b1101;
    case (kind_r)
      `K_QOUT: axClk = 6'd32;
      `K_QIO: begin
        axShift = {addr_r, modeByte_r};
        axClk = 6'd8;
        axQuad = 1'b1;
        axOe = 4'b1111;
      end
      `K_WRAP: begin
        axShift = {24'h000000, 1'b0, wrapBits_r, 4'h0};
        axClk = 6'd32;
      end
      default: axClk = 6'd24;
    endcase
  end

  wire [7:0] rxNext = segQuad_r ? {rxShift_r[3:0], ioSync} :
                      {rxShift_r[6:0], ioSync[1]};
  wire segState = (state_r == S_OPC) || (state_r == S_AX) ||
                  (state_r == S_DUMMY) || (state_r == S_RXD) ||
                  (state_r == S_TXD);
  // sclk parks low until software drains the last byte
  wire rxStall = (state_r == S_RXD) && rxValid_r && !flashSclk &&
                 (kind_r != `K_POLL);
  wire tickRun = (segState && !rxStall) || (state_r == S_FIN) ||
                 (state_r == S_GAP);
  wire rise = tick && segState && !rxStall && !flashSclk;
  wire fall = tick && segState && flashSclk;

  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wrEv = access && pwrite;
  wire rdEv = access && !pwrite;
  wire [2:0] newCmd = pwdata[2:0];
  wire newQuad = (newCmd == 3'd1) || (newCmd == 3'd3);
  wire newData = (newCmd == 3'd0) || (newCmd == 3'd1) ||
                 (newCmd == 3'd2) || (newCmd == 3'd3);
  wire startReq = wrEv && (paddr == `REG_CTRL) && pwdata[`CTRL_START];

  spi_tick_gen u_tick (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(tickRun),
    .tick(tick)
  );

  io_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pinIn(ioIn),
    .pinSync(ioSync)
  );

  // APB slave: no wait states, read data latched in setup
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      rxSnap_r <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= !mapped(paddr);
      rxSnap_r <= rxValid_r;
      prdata <= 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          `REG_CTRL: prdata <= {28'h0000000, mainKind_r};
          `REG_ADDR: prdata <= {8'h00, addr_r};
          `REG_LEN: prdata <= {16'h0000, len_r};
          `REG_TXDATA: prdata <= {24'h000000, txData_r};
          `REG_RXDATA: prdata <= {23'h000000, rxValid_r, rxData_r};
          `REG_CFG: prdata <= {13'h0000, wrapBits_r, modeByte_r,
                               6'h00, dummy10_r, quadOk_r};
          `REG_STATUS: prdata <= {26'h0000000, flashBusy_r, contMode_r,
                                  refused_r, rxValid_r, txValid_r,
                                  state_r != S_IDLE};
          default: prdata <= 32'h00000000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // software configuration
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_r <= 24'h000000;
      len_r <= `LEN_RST;
      quadOk_r <= 1'b0;
      dummy10_r <= 1'b0;
      modeByte_r <= `MODE_RST;
      wrapBits_r <= `WRAP_RST;
    end else if (wrEv && !pslverr) begin
      case (paddr)
        `REG_ADDR: addr_r <= pwdata[23:0];
        `REG_LEN: len_r <= pwdata[15:0];
        `REG_CFG: begin
          quadOk_r <= pwdata[`CFG_QUAD_OK];
          dummy10_r <= pwdata[`CFG_DUMMY10];
          modeByte_r <= pwdata[`CFG_MODE_HI:`CFG_MODE_LO];
          wrapBits_r <= pwdata[`CFG_WRAP_HI:`CFG_WRAP_LO];
        end
        default: ;
      endcase
    end
  end

  // sequencer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      segNext_r <= S_OPC;
      kind_r <= `K_QOUT;
      mainKind_r <= `K_QOUT;
      gapCnt_r <= 4'h0;
      txShift_r <= 32'h00000000;
      clkLeft_r <= 6'd0;
      segQuad_r <= 1'b0;
      segOe_r <= 4'h0;
      rxShift_r <= 8'h00;
      rxData_r <= 8'h00;
      txData_r <= 8'h00;
      byteLeft_r <= 16'h0000;
      contMode_r <= 1'b0;
      flashBusy_r <= 1'b0;
      refused_r <= 1'b0;
      txValid_r <= 1'b0;
      rxValid_r <= 1'b0;
      flashCsN <= 1'b1;
      flashSclk <= 1'b0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
    end else begin
      // clears first so a same-cycle set wins
      if (wrEv && paddr == `REG_STATUS && pwdata[`ST_REFUSED])
        refused_r <= 1'b0;
      if (rdEv && paddr == `REG_RXDATA && rxSnap_r)
        rxValid_r <= 1'b0;
      if (startReq) begin
        if (state_r != S_IDLE || (newQuad && !quadOk_r) ||
            (newData && len_r == 16'h0000) || newCmd > 3'd5) begin
          refused_r <= 1'b1;
        end else begin
          mainKind_r <= {1'b0, newCmd};
          state_r <= S_START;
          if (contMode_r && newCmd != 3'd1)
            kind_r <= `K_MRST;
          else if (needsWren({1'b0, newCmd}))
            kind_r <= `K_WRITE_ENABLE_CMD;
          else
            kind_r <= {1'b0, newCmd};
        end
      end
      if (fall || state_r == S_LEAD) begin
        if (fall)
          flashSclk <= 1'b0;
        ioOe <= segOe_r;
        if (segQuad_r) begin
          ioOut <= txShift_r[31:28];
          txShift_r <= {txShift_r[27:0], 4'h0};
        end else begin
          ioOut <= {3'b110, txShift_r[31]};
          txShift_r <= {txShift_r[30:0], 1'b0};
        end
      end
      case (state_r)
        S_START: begin
          state_r <= S_LEAD;
          if (kind_r == `K_QIO && contMode_r) begin
            txShift_r <= axShift;
            clkLeft_r <= axClk;
            segQuad_r <= axQuad;
            segOe_r <= axOe;
            segNext_r <= S_AX;
          end else begin
            txShift_r <= {opcodeOf(kind_r), 24'h000000};
            clkLeft_r <= 6'd8;
            segQuad_r <= 1'b0;
            segOe_r <= 4'b1101;
            segNext_r <= S_OPC;
          end
        end
        S_LEAD: begin
          flashCsN <= 1'b0;
          state_r <= segNext_r;
        end
        S_TXWAIT: begin
          if (txValid_r) begin
            txValid_r <= 1'b0;
            txShift_r <= {txData_r, 24'h000000};
            segQuad_r <= kind_r == `K_QPP;
            segOe_r <= 4'b1111;
            if (kind_r != `K_QPP)
              segOe_r <= 4'b1101;
            clkLeft_r <= (kind_r == `K_QPP) ? 6'd2 : 6'd8;
            state_r <= S_TXD;
          end
        end
        S_FIN: begin
          if (tick && flashSclk) begin
            flashSclk <= 1'b0;
          end else if (tick) begin
            flashCsN <= 1'b1;
            ioOe <= 4'h0;
            gapCnt_r <= 4'h0;
            state_r <= S_GAP;
          end
        end
        S_GAP: begin
          if (tick)
            gapCnt_r <= gapCnt_r + 4'h1;
          if (tick && gapCnt_r == `GAP_TICKS - 4'h1) begin
            state_r <= S_START;
            case (kind_r)
              `K_MRST: kind_r <= needsWren(mainKind_r) ? `K_WRITE_ENABLE_CMD :
                                 mainKind_r;
              `K_WRITE_ENABLE_CMD: kind_r <= mainKind_r;
              // wait out the self-timed cycle before the next order
              `K_POLL: if (!flashBusy_r) state_r <= S_IDLE;
              default: begin
                if (needsWren(kind_r))
                  kind_r <= `K_POLL;
                else
                  state_r <= S_IDLE;
              end
            endcase
          end
        end
        default: ;
      endcase
      if (rise) begin
        flashSclk <= 1'b1;
        rxShift_r <= rxNext;
        clkLeft_r <= clkLeft_r - 6'd1;
        if (clkLeft_r == 6'd1) begin
          case (state_r)
            S_OPC: begin
              if (kind_r == `K_MRST) begin
                contMode_r <= 1'b0;
                state_r <= S_FIN;
              end else if (kind_r == `K_WRITE_ENABLE_CMD) begin
                state_r <= S_FIN;
              end else if (kind_r == `K_POLL) begin
                clkLeft_r <= 6'd8;
                segQuad_r <= 1'b0;
                segOe_r <= 4'b1101;
                byteLeft_r <= 16'h0001;
                state_r <= S_RXD;
              end else begin
                txShift_r <= axShift;
                clkLeft_r <= axClk;
                segQuad_r <= axQuad;
                segOe_r <= axOe;
                state_r <= S_AX;
              end
            end
            S_AX: begin
              byteLeft_r <= len_r;
              txShift_r <= 32'h00000000;
              segOe_r <= 4'h0;
              case (kind_r)
                `K_QOUT: begin
                  clkLeft_r <= 6'd2;
                  segQuad_r <= 1'b1;
                  state_r <= S_RXD;
                end
                `K_QIO: begin
                  contMode_r <= modeByte_r[5:4] == `CONT_KEY;
                  clkLeft_r <= dummy10_r ? `QIO_WAIT_LONG :
                               `QIO_WAIT_DEF;
                  state_r <= S_DUMMY;
                end
                `K_PP, `K_QPP: state_r <= S_TXWAIT;
                default: state_r <= S_FIN;
              endcase
            end
            S_DUMMY: begin
              clkLeft_r <= 6'd2;
              state_r <= S_RXD;
            end
            S_RXD: begin
              if (kind_r == `K_POLL) begin
                flashBusy_r <= rxNext[0];
                state_r <= S_FIN;
              end else begin
                rxData_r <= rxNext;
                rxValid_r <= 1'b1;
                byteLeft_r <= byteLeft_r - 16'h0001;
                clkLeft_r <= segQuad_r ? 6'd2 : 6'd8;
                if (byteLeft_r == 16'h0001)
                  state_r <= S_FIN;
              end
            end
            S_TXD: begin
              byteLeft_r <= byteLeft_r - 16'h0001;
              if (byteLeft_r == 16'h0001)
                state_r <= S_FIN;
              else
                state_r <= S_TXWAIT;
            end
            default: state_r <= S_FIN;
          endcase
        end
      end
      if (wrEv && paddr == `REG_TXDATA) begin
        txData_r <= pwdata[7:0];
        txValid_r <= 1'b1;
      end
    end
  end
endmodule

// File: flash_host_chk.sv
// port checker for the flash host controller
`timescale 1ns/1ps
module flash_host_chk (
  input wire clk_sys,       // clock
  input wire sys_rst,       // reset
  input wire [7:0] paddr,   // apb address
  input wire psel,          // apb select
  input wire penable,       // apb enable
  input wire pwrite,        // apb write
  input wire [31:0] pwdata, // apb write data
  input wire [31:0] prdata, // apb read data
  input wire pready,        // apb ready
  input wire pslverr,       // apb error
  input wire flashCsN,      // chip select
  input wire flashSclk,     // serial clock
  input wire [3:0] ioIn,    // pins in
  input wire [3:0] ioOut,   // pins out
  input wire [3:0] ioOe     // pin enables
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence hiHalf;
    flashSclk [*4];
  endsequence
  sequence loHalf;
    !flashSclk [*4];
  endsequence
  rdy_one_cycle_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  bad_addr_a: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
    else $error("unmapped address without error");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_quiet_a: assert property (flashCsN |-> !flashSclk && !ioOe)
    else $error("pins active while deselected");
  cs_gap_a: assert property ($rose(flashCsN) |-> flashCsN [*8])
    else $error("deselect gap too short");
  first_edge_a: assert property ($fell(flashCsN) |-> loHalf)
    else $error("first clock edge too early");
  half_high_a: assert property ($rose(flashSclk) |-> hiHalf)
    else $error("clock high phase too short");
  half_low_a: assert property ($fell(flashSclk) && !flashCsN
    |-> loHalf)
    else $error("clock low phase too short");
  clk_in_frame_a: assert property ($rose(flashSclk) |-> !flashCsN)
    else $error("clock edge outside a frame");
  hold_high_a: assert property (flashSclk && $past(flashSclk)
    |-> $stable(ioOut) && $stable(ioOe))
    else $error("pins moved while clock high");
  oe_shape_a: assert property (!flashCsN
    |-> ioOe inside {4'h0, 4'hd, 4'hf})
    else $error("illegal pin enable pattern");
endmodule
bind flash_host_ctrl flash_host_chk chk (.*);

// File: flash_model.sv
// behavioural serial nor flash on the far side of the pins
`timescale 1ns/1ps
module flash_model (
  input wire csN,          // chip select, active low
  input wire sclk,         // serial clock
  input wire [3:0] io,     // resolved pin levels
  output logic [3:0] dOut, // device drive values
  output logic [3:0] dOe   // device drive enables
);
  // stands for program and erase cycle time, kept short
  parameter int CYCLE_NS = 400;
  logic [7:0] mem [0:2047];
  logic [7:0] pg [0:255];
  logic pv [0:255];
  logic write_enable_latch = 0, write_in_progress = 0, qe = 1, dc = 0, cont = 0, prot = 0;
  logic [2:0] wrap = 3'h1;
  logic [7:0] op;
  logic [23:0] a;
  int n = 0;
  initial dOut = 0;
  initial dOe = 0;
  task automatic rx(input int k, input bit q, output logic [31:0] v);
    v = 0;
    repeat (k) begin
      @(posedge sclk);
      v = q ? {v[27:0], io} : {v[30:0], io[0]};
      n += q ? 4 : 1;
    end
  endtask
  task automatic tx(input logic [7:0] b, input bit q);
    for (int i = q ? 1 : 7; i >= 0; i--) begin
      @(negedge sclk);
      dOe = q ? 4'hf : 4'h2;
      dOut = q ? b[i*4+:4] : {2'b0, b[i], 1'b0};
    end
  endtask
  task automatic body();
    logic [31:0] v;
    int k;
    op = 8'heb;
    if (!cont) rx(8, 0, v);
    if (!cont) op = v[7:0];
    n = 0;
    case (op)
      8'h06: write_enable_latch = 1'b1;
      8'h05: forever tx({6'h0, write_enable_latch, write_in_progress}, 0);
      8'h77: begin
        rx(32, 0, v);
        wrap = v[6:4];
      end
      8'h6b: begin
        rx(32, 0, v);
        a = v[31:8];
        forever begin
          tx(mem[a[10:0]], 1);
          a++;
        end
      end
      8'heb: if (qe) begin
        rx(6, 1, v);
        a = v[23:0];
        rx(2, 1, v);
        cont = v[5:4] == 2'b10;
        rx(dc ? 8 : 4, 1, v);
        k = 8 << wrap[2:1];
        forever begin
          tx(mem[a[10:0]], 1);
          a = wrap[0] ? a + 1 : a & ~(k - 1) | a + 1 & k - 1;
        end
      end
      8'h02, 8'h32: begin
        rx(24, 0, v);
        a = v[23:0];
        foreach (pv[i]) pv[i] = 0;
        forever begin
          rx(op == 8'h02 ? 8 : 2, op == 8'h32, v);
          pg[a[7:0]] = v[7:0];
          pv[a[7:0]] = 1;
          a[7:0]++;
        end
      end
      8'h20: rx(24, 0, v);
      default: ;
    endcase
  endtask
  task automatic commit();
    if (!write_enable_latch || write_in_progress) return;
    if (op == 8'h20 && n == 24 && !prot) begin
      foreach (mem[i]) mem[i] = 8'hff;
      write_in_progress = 1'b1;
    end
    if ((op == 8'h02 || op == 8'h32 && qe) && n > 24 && n % 8 == 0
        && !prot) begin
      foreach (pv[i]) if (pv[i]) mem[{a[10:8], i[7:0]}] = pg[i];
      write_in_progress = 1'b1;
    end
  endtask
  always begin
    @(negedge csN);
    n = 0;
    fork
      begin
        body();
        forever begin
          @(posedge sclk);
          n++;
        end
      end
      @(posedge csN);
    join_any
    disable fork;
    dOe = 0;
    commit();
  end
  always @(posedge write_in_progress) begin
    #(CYCLE_NS);
    write_enable_latch = 0;
    write_in_progress = 0;
  end
endmodule

// File: tb_top.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module tb_top;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic pready, pslverr, flashCsN, flashSclk, perr;
  logic [3:0] ioIn, ioOut, ioOe, dOut, dOe, junk = 0;
  int numErrors = 0, compares = 0;
  flash_host_ctrl uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flashCsN(flashCsN), .flashSclk(flashSclk),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  flash_model fm (.csN(flashCsN), .sclk(flashSclk), .io(ioIn),
    .dOut(dOut), .dOe(dOe));
  // released pins wander so a stale level never passes
  always @(posedge clk_sys) junk <= junk + 4'h5;
  assign ioIn = ioOe & ioOut | ~ioOe & (dOe & dOut | ~dOe & junk);
  initial forever #2 clk_sys = ~clk_sys;
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] pat(input logic [10:0] x);
    return x[7:0] ^ {5'h0, x[10:8]} ^ 8'h5a;
  endfunction
  function automatic logic [7:0] dat(input int j);
    return 8'(j) + 8'hc0 ^ {8{j[8]}};
  endfunction
  task automatic apb(input logic [7:0] ad, input logic w,
      input logic [31:0] d);
    int t = 0;
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 40);
    if (t >= 40) begin
      numErrors++;
      tally_and_finish();
    end
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic waitBit(input logic [7:0] ad, input int b, input logic v);
    int t = 0;
    do begin
      apb(ad, 1'b0, 32'h0);
      t++;
    end while (rdv[b] !== v && t < 4000);
    if (t >= 4000) begin
      numErrors++;
      tally_and_finish();
    end
  endtask
  task automatic cfg(input logic [2:0] w, input logic [7:0] m, input bit d);
    fm.dc = d;
    apb(`REG_CFG, 1'b1, {13'h0, w, m, 6'h0, d, 1'b1});
  endtask
  task automatic resetRun();
    apb(`REG_CFG, 1'b0, 32'h0);
    chk("cfg reset", rdv[18:8], 11'h100);
    apb(`REG_LEN, 1'b0, 32'h0);
    chk("len reset", rdv[15:0], `LEN_RST);
    apb(8'h1c, 1'b0, 32'h0);
    chk("unmapped err", perr, 1'b1);
    chk("unmapped data", rdv, 32'h0);
  endtask
  task automatic refuseRun();
    logic [2:0] cs [3] = '{3'h6, 3'h7, 3'h1};
    apb(`REG_CFG, 1'b1, 32'h10000);
    foreach (cs[i]) begin
      apb(`REG_CTRL, 1'b1, 32'h100 | cs[i]);
      waitBit(`REG_STATUS, `ST_REFUSED, 1'b1);
      apb(`REG_STATUS, 1'b1, 32'h8);
      apb(`REG_STATUS, 1'b0, 32'h0);
      chk("refused clear", rdv[`ST_REFUSED], 1'b0);
    end
  endtask
  task automatic readRun(input logic [2:0] c, input logic [23:0] a,
      input int k, input int n);
    logic [23:0] x;
    apb(`REG_ADDR, 1'b1, a);
    apb(`REG_LEN, 1'b1, n);
    apb(`REG_CTRL, 1'b1, 32'h100 | c);
    for (int j = 0; j < n; j++) begin
      x = k > 0 ? a & ~(k - 1) | a + j & k - 1 : a + j;
      waitBit(`REG_RXDATA, `RXD_VALID, 1'b1);
      chk("read byte", rdv[7:0], pat(x[10:0]));
    end
    waitBit(`REG_STATUS, `ST_BUSY, 1'b0);
  endtask
  task automatic wrapSet(input logic [2:0] w);
    cfg(w, 8'h00, 1'b0);
    apb(`REG_CTRL, 1'b1, 32'h105);
    waitBit(`REG_STATUS, `ST_BUSY, 1'b0);
    chk("wrap bits", fm.wrap, w);
  endtask
  task automatic progRun(input logic [2:0] c, input logic [23:0] a,
      input int n, input bit pr);
    logic [10:0] x;
    fm.prot = pr;
    apb(`REG_ADDR, 1'b1, a);
    apb(`REG_LEN, 1'b1, n);
    apb(`REG_TXDATA, 1'b1, dat(0));
    apb(`REG_CTRL, 1'b1, 32'h100 | c);
    for (int j = 1; j < n; j++) begin
      waitBit(`REG_STATUS, `ST_TX_FULL, 1'b0);
      apb(`REG_TXDATA, 1'b1, dat(j));
    end
    waitBit(`REG_STATUS, `ST_BUSY, 1'b0);
    // one byte past a short burst must be left alone
    for (int j = n < 256 ? 0 : n - 256; j < (n < 256 ? n + 1 : n); j++) begin
      x = {a[10:8], a[7:0] + j[7:0]};
      chk("page byte", fm.mem[x], pr || j == n ? pat(x) : dat(j));
    end
    chk("enable latch", fm.write_enable_latch, pr);
    fm.prot = 0;
  endtask
  task automatic eraseRun(input bit pr);
    fm.prot = pr;
    apb(`REG_ADDR, 1'b1, 32'h123);
    apb(`REG_CTRL, 1'b1, 32'h104);
    waitBit(`REG_STATUS, `ST_BUSY, 1'b0);
    chk("erased", fm.mem[11'h7f3], pr ? pat(11'h7f3) : 8'hff);
    fm.prot = 0;
  endtask
  initial begin
    for (int i = 0; i < 2048; i++) fm.mem[i] = pat(11'(i));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    resetRun();
    refuseRun();
    readRun(3'h0, 24'h1fd, 0, 5);
    for (int d = 0; d < 2; d++) begin
      cfg(3'h1, 8'h00, d[0]);
      readRun(3'h1, 24'h033, 0, 3);
    end
    for (int w = 0; w < 4; w++) begin
      wrapSet({w[1:0], 1'b0});
      readRun(3'h1, 24'h0a5, 8 << w, (8 << w) + 3);
    end
    wrapSet(3'h1);
    cfg(3'h1, 8'h20, 1'b0);
    readRun(3'h1, 24'h040, 0, 2);
    chk("cont on", fm.cont, 1'b1);
    readRun(3'h1, 24'h150, 0, 2);
    apb(`REG_STATUS, 1'b0, 32'h0);
    chk("cont flag", rdv[`ST_CONT], 1'b1);
    cfg(3'h1, 8'h00, 1'b0);
    progRun(3'h2, 24'h1fe, 3, 1'b0);
    chk("cont off", fm.cont, 1'b0);
    progRun(3'h3, 24'h280, 2, 1'b0);
    progRun(3'h2, 24'h310, 2, 1'b1);
    progRun(3'h2, 24'h4fe, 258, 1'b0);
    eraseRun(1'b1);
    eraseRun(1'b0);
    tally_and_finish();
  end
endmodule
